/* tpec_pkg.sv */
// Constants shared by the test pattern and exposure configuration block
package tpec_pkg;

   // Register slots, printed index per slot; byte address is four times the index
   localparam int REG_COUNT  = 16;
   localparam int SLOT_TEST  = 0;
   localparam int SLOT_LOW01 = 2;
   localparam int SLOT_LOW23 = 3;
   localparam int SLOT_HIGH  = 6;
   localparam int SLOT_CTRL  = 9;
   localparam int SLOT_TGT   = 10;
   localparam int SLOT_WRED  = 11;
   localparam int SLOT_WGA   = 12;
   localparam int SLOT_WGB   = 13;
   localparam int SLOT_SGAIN = 14;
   localparam int SLOT_SAVG  = 15;

   localparam logic [7:0] REG_INDEX [REG_COUNT] = '{
      8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h9a,
      8'h9b, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha8, 8'ha9};
   localparam logic [15:0] REG_RESET [REG_COUNT] = '{
      16'h0000, 16'h0000, 16'h0100, 16'h0302, 16'h0504, 16'h0706, 16'h0000, 16'h0000,
      16'h0000, 16'h0010, 16'h60b8, 16'h0080, 16'h0080, 16'h0080, 16'h0000, 16'h0000};
   // Writable bits; restart bit is a pulse and never stored
   localparam logic [15:0] REG_MASK [REG_COUNT] = '{
      16'h0001, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'h001d, 16'h3fff, 16'h03ff, 16'h03ff, 16'h03ff, 16'h0000, 16'h0000};

   // Field positions
   localparam int TEST_PAT_EN  = 0;
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_RESTART = 1;
   localparam int CTRL_FREEZE  = 2;
   localparam int CTRL_SUBSMP  = 3;
   localparam int CTRL_AMP_PRI = 4;
   localparam int TGT_MSB      = 9;
   localparam int CLIP_LSB     = 10;
   localparam int CLIP_MSB     = 13;

   // Arithmetic constants
   localparam int          WEIGHT_FRAC = 7;
   localparam int          CLIP_FRAC   = 3;
   localparam int          FILT_SHIFT  = 4;
   localparam logic [9:0]  WEIGHT_UNIT = 10'h080;
   localparam logic [11:0] GAIN_UNIT   = 12'h080;
   localparam logic [11:0] GAIN_MAX    = 12'hfff;
   localparam logic [1:0]  STAGE_MAX   = 2'h3;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : tpec_pkg

/* tpec_stat.sv */
// Weighted, subsampled intensity averaging filter of the exposure loop
module tpec_stat (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Pixel stream
   input  wire logic       pix_valid,
   input  wire logic [9:0] pix_value,
   input  wire logic [1:0] pix_color,
   input  wire logic       frame_end,
   // Configuration
   input  wire logic       subsample,
   input  wire logic       restart,
   input  wire logic       freeze,
   input  wire logic [9:0] w_red,
   input  wire logic [9:0] w_ga,
   input  wire logic [9:0] w_gb,
   // Filtered average
   output logic      [9:0] avg
);

   logic [1:0]  pix_cnt;
   logic [9:0]  weight;
   logic [19:0] product;
   logic [9:0]  sample;
   logic [11:0] diff;
   logic        take;

   // Subsampling counter, restarted each frame
   always_ff @(posedge clk)
   begin
      if (rst || frame_end)
         pix_cnt <= 2'h0;
      else if (pix_valid)
         pix_cnt <= pix_cnt + 2'h1;
   end

   // Pick the colour weight and scale the pixel
   always_comb
   begin
      take = pix_valid && (!subsample || pix_cnt == 2'h0);
      unique case (pix_color)
         2'd0: weight = w_red;
         2'd1: weight = w_ga;
         2'd2: weight = w_gb;
         2'd3: weight = tpec_pkg::WEIGHT_UNIT;
      endcase
      product = pix_value * weight;
      sample  = (|product[19:17]) ? 10'h3ff : product[16:7];
      diff    = {2'b00, sample} - {2'b00, avg};
   end

   // Running average; restart clears it, freeze holds it
   always_ff @(posedge clk)
   begin
      if (rst || restart)
         avg <= 10'h000;
      else if (take && !freeze)
         avg <= avg + 10'(($signed(diff)) >>> tpec_pkg::FILT_SHIFT);
   end

endmodule : tpec_stat

/* tpec_gain.sv */
// Frame-rate gain regulator and gain-stage distribution
module tpec_gain (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Control
   input  wire logic        frame_end,
   input  wire logic        enable,
   input  wire logic        freeze,
   input  wire logic        amp_pri,
   input  wire logic [9:0]  target,
   input  wire logic [3:0]  clip,
   input  wire logic [9:0]  avg,
   // Applied gains
   output logic      [11:0] gain,
   output logic      [1:0]  stage1,
   output logic      [1:0]  stage2
);

   logic [13:0] scaled;
   logic [15:0] boost;
   logic [11:0] next_gain;
   logic [3:0]  steps;
   logic [1:0]  first;
   logic [3:0]  rest;

   // Step toward the target, increase limited by the clip factor
   always_comb
   begin
      scaled = avg * clip;
      boost  = gain * clip;
      next_gain = gain;
      if (avg < target)
      begin
         if (clip > 4'h8 && 11'(scaled >> tpec_pkg::CLIP_FRAC) <= {1'b0, target})
            next_gain = (|boost[15:15]) ? tpec_pkg::GAIN_MAX : boost[14:3];
         else if (gain != tpec_pkg::GAIN_MAX)
            next_gain = gain + 12'h001;
      end
      else if (avg > target && gain > tpec_pkg::GAIN_UNIT)
         next_gain = gain - 12'h001;
   end

   // Gain register, updated once per frame
   always_ff @(posedge clk)
   begin
      if (rst)
         gain <= tpec_pkg::GAIN_UNIT;
      else if (frame_end && enable && !freeze)
         gain <= next_gain;
   end

   // Spread analog steps over the stages by priority
   always_comb
   begin
      steps = gain[11:8];
      first = (steps > 4'h3) ? tpec_pkg::STAGE_MAX : steps[1:0];
      rest  = steps - {2'b00, first};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage1 <= 2'h0;
         stage2 <= 2'h0;
      end
      else if (amp_pri)
      begin
         stage1 <= first;
         stage2 <= (rest > 4'h3) ? tpec_pkg::STAGE_MAX : rest[1:0];
      end
      else
      begin
         stage2 <= first;
         stage1 <= (rest > 4'h3) ? tpec_pkg::STAGE_MAX : rest[1:0];
      end
   end

endmodule : tpec_gain

/* tpec_top.sv */
// Register bank, lane pattern insertion and exposure loop top
module tpec_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AXI4-Lite write address and data
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Lane datapaths, lane n in bits 10n+9:10n
   input  wire logic [39:0] lane_data_in,
   output logic      [39:0] lane_data_out,
   output logic             pattern_active,
   // Pixel statistics input
   input  wire logic        pix_valid,
   input  wire logic [9:0]  pix_value,
   input  wire logic [1:0]  pix_color,
   input  wire logic        frame_end,
   // Applied gains
   output logic      [11:0] gain_digital,
   output logic      [1:0]  gain_stage1,
   output logic      [1:0]  gain_stage2
);

   logic [15:0] regs [tpec_pkg::REG_COUNT];
   logic [9:0]  lane_q [4];
   logic [9:0]  aw_addr;
   logic        aw_full;
   logic        w_full;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_full;
   logic        next_w_full;
   logic        next_bvalid;
   logic        do_write;
   logic        wr_hit;
   logic        rd_hit;
   logic [15:0] rd_value;
   logic [15:0] strb_mask;
   logic        restart_pulse;
   logic [9:0]  avg;
   logic        ar_take;

   // Write channel state: each side is held until both are in
   always_comb
   begin
      do_write     = aw_full && w_full && !s_axi_bvalid;
      next_aw_full = aw_full;
      next_w_full  = w_full;
      next_bvalid  = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
         next_aw_full = 1'b1;
      if (s_axi_wvalid && s_axi_wready)
         next_w_full = 1'b1;
      if (do_write)
      begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
   end

   // Address and data capture registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_addr <= 10'h000;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            aw_addr <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // Write handshake flops; ready drops while a side is held
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         aw_full       <= next_aw_full;
         w_full        <= next_w_full;
         s_axi_bvalid  <= next_bvalid;
         s_axi_awready <= !next_aw_full && !next_bvalid;
         s_axi_wready  <= !next_w_full && !next_bvalid;
      end
   end

   // Write decode and byte lane mask
   always_comb
   begin
      wr_hit    = 1'b0;
      strb_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
      for (int i = 0; i < tpec_pkg::REG_COUNT; i++)
      begin
         if (aw_addr[9:2] == tpec_pkg::REG_INDEX[i])
            wr_hit = 1'b1;
      end
   end

   // Write response; unmapped addresses answer slave error
   always_ff @(posedge clk)
   begin
      if (rst)
         s_axi_bresp <= tpec_pkg::RESP_OKAY;
      else if (do_write)
         s_axi_bresp <= wr_hit ? tpec_pkg::RESP_OKAY : tpec_pkg::RESP_SLVERR;
   end

   // Filter restart is a one-cycle pulse on a write of control bit 1
   always_ff @(posedge clk)
   begin
      if (rst)
         restart_pulse <= 1'b0;
      else
         restart_pulse <= do_write && w_strb[0] && w_data[tpec_pkg::CTRL_RESTART]
            && aw_addr[9:2] == tpec_pkg::REG_INDEX[tpec_pkg::SLOT_CTRL];
   end

   // Register storage; status slots track live loop state
   for (genvar i = 0; i < tpec_pkg::REG_COUNT; i++)
   begin : g_reg
      always_ff @(posedge clk)
      begin
         if (rst)
            regs[i] <= tpec_pkg::REG_RESET[i];
         else if (i == tpec_pkg::SLOT_SGAIN)
            regs[i] <= {4'h0, gain_digital};
         else if (i == tpec_pkg::SLOT_SAVG)
            regs[i] <= {6'h00, avg};
         else if (do_write && aw_addr[9:2] == tpec_pkg::REG_INDEX[i])
            regs[i] <= (regs[i] & ~(strb_mask & tpec_pkg::REG_MASK[i]))
               | (w_data[15:0] & strb_mask & tpec_pkg::REG_MASK[i]);
      end
   end

   // Read decode; unmapped reads return zero
   always_comb
   begin
      rd_hit   = 1'b0;
      rd_value = 16'h0000;
      ar_take  = s_axi_arvalid && s_axi_arready;
      for (int i = 0; i < tpec_pkg::REG_COUNT; i++)
      begin
         if (s_axi_araddr[9:2] == tpec_pkg::REG_INDEX[i])
         begin
            rd_hit   = 1'b1;
            rd_value = regs[i];
         end
      end
   end

   // Read channel: one read under way at a time
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= tpec_pkg::RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {16'h0000, rd_value};
         s_axi_rresp   <= rd_hit ? tpec_pkg::RESP_OKAY : tpec_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // Lane insertion: pattern words replace lane data when enabled
   for (genvar l = 0; l < 4; l++)
   begin : g_lane
      always_ff @(posedge clk)
      begin
         if (rst)
            lane_q[l] <= 10'h000;
         else if (regs[tpec_pkg::SLOT_TEST][tpec_pkg::TEST_PAT_EN])
            lane_q[l] <= {regs[tpec_pkg::SLOT_HIGH][2*l+:2],
               regs[tpec_pkg::SLOT_LOW01 + l/2][8*(l%2)+:8]};
         else
            lane_q[l] <= lane_data_in[10*l+:10];
      end
   end

   assign lane_data_out = {lane_q[3], lane_q[2], lane_q[1], lane_q[0]};

   // Pattern enable mirrored out
   always_ff @(posedge clk)
   begin
      if (rst)
         pattern_active <= 1'b0;
      else
         pattern_active <= regs[tpec_pkg::SLOT_TEST][tpec_pkg::TEST_PAT_EN];
   end

   // Intensity statistics
   tpec_stat u_stat (
      .clk       (clk),
      .rst       (rst),
      .pix_valid (pix_valid),
      .pix_value (pix_value),
      .pix_color (pix_color),
      .frame_end (frame_end),
      .subsample (regs[tpec_pkg::SLOT_CTRL][tpec_pkg::CTRL_SUBSMP]),
      .restart   (restart_pulse),
      .freeze    (regs[tpec_pkg::SLOT_CTRL][tpec_pkg::CTRL_FREEZE]),
      .w_red     (regs[tpec_pkg::SLOT_WRED][9:0]),
      .w_ga      (regs[tpec_pkg::SLOT_WGA][9:0]),
      .w_gb      (regs[tpec_pkg::SLOT_WGB][9:0]),
      .avg       (avg)
   );

   // Gain regulator
   tpec_gain u_gain (
      .clk       (clk),
      .rst       (rst),
      .frame_end (frame_end),
      .enable    (regs[tpec_pkg::SLOT_CTRL][tpec_pkg::CTRL_ENABLE]),
      .freeze    (regs[tpec_pkg::SLOT_CTRL][tpec_pkg::CTRL_FREEZE]),
      .amp_pri   (regs[tpec_pkg::SLOT_CTRL][tpec_pkg::CTRL_AMP_PRI]),
      .target    (regs[tpec_pkg::SLOT_TGT][tpec_pkg::TGT_MSB:0]),
      .clip      (regs[tpec_pkg::SLOT_TGT][tpec_pkg::CLIP_MSB:tpec_pkg::CLIP_LSB]),
      .avg       (avg),
      .gain      (gain_digital),
      .stage1    (gain_stage1),
      .stage2    (gain_stage2)
   );

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_lane0_pattern: assert property (
      regs[tpec_pkg::SLOT_TEST][0] |=> lane_data_out[9:0] ==
         {$past(regs[tpec_pkg::SLOT_HIGH][1:0]), $past(regs[tpec_pkg::SLOT_LOW01][7:0])})
      else $error("lane 0 pattern wrong");

   a_lane1_pattern: assert property (
      regs[tpec_pkg::SLOT_TEST][0] |=> lane_data_out[19:10] ==
         {$past(regs[tpec_pkg::SLOT_HIGH][3:2]), $past(regs[tpec_pkg::SLOT_LOW01][15:8])})
      else $error("lane 1 pattern wrong");

   a_lane2_pattern: assert property (
      regs[tpec_pkg::SLOT_TEST][0] |=> lane_data_out[29:20] ==
         {$past(regs[tpec_pkg::SLOT_HIGH][5:4]), $past(regs[tpec_pkg::SLOT_LOW23][7:0])})
      else $error("lane 2 pattern wrong");

   a_lane3_pattern: assert property (
      regs[tpec_pkg::SLOT_TEST][0] |=> lane_data_out[39:30] ==
         {$past(regs[tpec_pkg::SLOT_HIGH][7:6]), $past(regs[tpec_pkg::SLOT_LOW23][15:8])})
      else $error("lane 3 pattern wrong");

   a_restart_clears: assert property (
      restart_pulse |=> avg == 10'h000)
      else $error("filter restart did not clear average");

   a_disabled_holds: assert property (
      !regs[tpec_pkg::SLOT_CTRL][0] |=> $stable(gain_digital))
      else $error("gain moved while loop disabled");

   a_freeze_holds: assert property (
      regs[tpec_pkg::SLOT_CTRL][2] |=> $stable(gain_digital) && $stable(avg))
      else $error("state moved while frozen");

   a_stage_priority: assert property (
      regs[tpec_pkg::SLOT_CTRL][4] && $stable(regs[tpec_pkg::SLOT_CTRL][4])
         && gain_stage2 != 2'h0 |-> gain_stage1 == 2'h3)
      else $error("stage 1 not filled first");

   a_gain_rises: assert property (
      frame_end && regs[tpec_pkg::SLOT_CTRL][0] && !regs[tpec_pkg::SLOT_CTRL][2]
         && avg < regs[tpec_pkg::SLOT_TGT][9:0] && gain_digital != 12'hfff
         |=> gain_digital > $past(gain_digital))
      else $error("gain did not rise below target");

   a_write_answer: assert property (
      do_write |=> s_axi_bvalid ##0 (s_axi_bresp == tpec_pkg::RESP_OKAY) == $past(wr_hit))
      else $error("write response wrong");

   a_read_answer: assert property (
      ar_take |=> s_axi_rvalid && (s_axi_rresp == tpec_pkg::RESP_OKAY) == $past(rd_hit))
      else $error("read response wrong");

   a_pattern_flag: assert property (
      pattern_active == $past(regs[tpec_pkg::SLOT_TEST][tpec_pkg::TEST_PAT_EN]))
      else $error("pattern flag does not follow enable");

   a_lane_bypass: assert property (
      !regs[tpec_pkg::SLOT_TEST][0] |=> lane_data_out == $past(lane_data_in))
      else $error("lane data not passed through");

endmodule : tpec_top

/* tpec_host.sv */
// Host model that configures the block over its register bus
module tpec_host (
   // Clock
   input  wire logic        clk,
   // Write address, data and response
   output logic      [9:0]  s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic      [31:0] s_axi_wdata,
   output logic      [3:0]  s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   // Read address and data
   output logic      [9:0]  s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Set when the slave never answers
   logic stuck;

   // Idle bus at time zero
   initial
   begin
      stuck = 1'b0;
      s_axi_awaddr = 10'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 10'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end

   // One write: address and data offered together, each dropped once taken
   task automatic write_word(input logic [9:0] addr, input logic [15:0] data,
                             output logic [1:0] resp);
      int   n;
      logic aw_open;
      logic w_open;
      n = 0;
      aw_open = 1'b1;
      w_open = 1'b1;
      resp = 2'b11;
      @(posedge clk);
      s_axi_awaddr <= addr;
      s_axi_wdata <= {16'h0000, data};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (n < 100)
      begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'b1) aw_open = 1'b0;
         if (s_axi_wready === 1'b1) w_open = 1'b0;
         s_axi_awvalid <= aw_open;
         s_axi_wvalid <= w_open;
         if (s_axi_bvalid === 1'b1) n = 1000;
      end
      s_axi_bready <= 1'b0;
      if (n < 1000) stuck = 1'b1;
      else resp = s_axi_bresp;
   endtask : write_word

   // One read; rready held until the answer is sampled
   task automatic read_word(input logic [9:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
      int   n;
      logic ar_open;
      n = 0;
      ar_open = 1'b1;
      data = 32'hdead_beef;
      resp = 2'b11;
      @(posedge clk);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (n < 100)
      begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'b1) ar_open = 1'b0;
         s_axi_arvalid <= ar_open;
         if (s_axi_rvalid === 1'b1) n = 1000;
      end
      s_axi_rready <= 1'b0;
      if (n < 1000) stuck = 1'b1;
      else
      begin
         data = s_axi_rdata;
         resp = s_axi_rresp;
      end
   endtask : read_word
endmodule : tpec_host

/* tb.sv */
// Self-checking bench of the test pattern and exposure configuration block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] OK = tpec_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = tpec_pkg::RESP_SLVERR;
   logic        clk;
   logic        rst;
   logic [9:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [9:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic [39:0] lane_data_in;
   logic [39:0] lane_data_out;
   logic        pattern_active;
   logic        pix_valid;
   logic [9:0]  pix_value;
   logic [1:0]  pix_color;
   logic        frame_end;
   logic [11:0] gain_digital;
   logic [1:0]  gain_stage1;
   logic [1:0]  gain_stage2;
   int          err_total = 0;
   int          samples_checked = 0;
   int          g;
   int          k;
   logic [15:0] d;

   tpec_top i_tpec_top (.clk(clk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lane_data_in(lane_data_in),
      .lane_data_out(lane_data_out), .pattern_active(pattern_active), .pix_valid(pix_valid),
      .pix_value(pix_value), .pix_color(pix_color), .frame_end(frame_end),
      .gain_digital(gain_digital), .gain_stage1(gain_stage1), .gain_stage2(gain_stage2));

   tpec_host i_tpec_host (.clk(clk),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Print the counts and the verdict, then stop
   task automatic give_verdict();
      $display("Compared %0d results, %0d mismatches", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   // Compare one result against the model
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // A hung bus counts as a mismatch and ends the run
   task automatic guard();
      if (i_tpec_host.stuck === 1'b1)
      begin
         err_total++;
         give_verdict();
      end
   endtask : guard

   // Register write and read at printed index idx, byte address four times it
   task automatic wreg(input logic [7:0] idx, input logic [15:0] v, input logic [1:0] er);
      logic [1:0] r;
      i_tpec_host.write_word({idx, 2'b00}, v, r);
      guard();
      chk({30'h0, r}, {30'h0, er});
   endtask : wreg

   task automatic rreg(input logic [7:0] idx, input logic [15:0] v, input logic [1:0] er);
      logic [31:0] x;
      logic [1:0]  r;
      i_tpec_host.read_word({idx, 2'b00}, x, r);
      guard();
      chk(x, {16'h0000, v});
      chk({30'h0, r}, {30'h0, er});
   endtask : rreg

   // One-cycle end-of-frame pulse
   task automatic frame_pulse();
      @(posedge clk);
      frame_end <= 1'b1;
      @(posedge clk);
      frame_end <= 1'b0;
   endtask : frame_pulse

   // Random pattern bytes, lane inputs, then the four lane outputs
   task automatic lane_case(input logic en);
      logic [15:0] lo01;
      logic [15:0] lo23;
      logic [15:0] hi;
      logic [39:0] din;
      logic [39:0] exp;
      lo01 = 16'($urandom);
      lo23 = 16'($urandom);
      hi = 16'($urandom);
      din = {8'($urandom), 32'($urandom)};
      wreg(8'h92, lo01, OK);
      wreg(8'h93, lo23, OK);
      wreg(8'h96, hi, OK);
      wreg(8'h90, {15'h0000, en}, OK);
      exp = en ? {hi[7:6], lo23[15:8], hi[5:4], lo23[7:0],
                  hi[3:2], lo01[15:8], hi[1:0], lo01[7:0]} : din;
      @(posedge clk);
      lane_data_in <= din;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({24'h0, lane_data_out[39:32]}, {24'h0, exp[39:32]});
      chk(lane_data_out[31:0], exp[31:0]);
      chk({31'h0, pattern_active}, {31'h0, en});
   endtask : lane_case

   // Pixels of colour sel with weight w, then the filtered average
   task automatic stat_case(input logic [1:0] sel, input logic [15:0] ctrl,
                            input logic [9:0] w, input int n);
      int a;
      int i;
      a = 0;
      wreg(8'ha2 + 8'(sel), {6'h00, w}, OK);
      wreg(8'ha0, ctrl, OK);
      frame_pulse();
      for (i = 0; i < n; i++)
      begin
         @(posedge clk);
         pix_valid <= 1'b1;
         pix_value <= 10'h100;
         pix_color <= sel;
         if (ctrl[3] == 1'b0 || i % 4 == 0) a = a + ((256 * int'(w) / 128 - a) >>> 4);
      end
      @(posedge clk);
      pix_valid <= 1'b0;
      rreg(8'ha9, 16'(a), OK);
   endtask : stat_case

   // One frame of the loop below target with clip 1.5, then gains
   task automatic gain_frame(input logic [15:0] ctrl);
      int s;
      int p;
      int o;
      wreg(8'ha0, ctrl, OK);
      frame_pulse();
      repeat (2) @(posedge clk);
      if (ctrl[0] && !ctrl[2]) g = (g * 12 / 8 > 4095) ? 4095 : g * 12 / 8;
      s = g / 256;
      p = (s > 3) ? 3 : s;
      o = (s - p > 3) ? 3 : s - p;
      @(negedge clk);
      chk({20'h0, gain_digital}, 32'(g));
      chk({30'h0, ctrl[4] ? gain_stage1 : gain_stage2}, 32'(p));
      chk({30'h0, ctrl[4] ? gain_stage2 : gain_stage1}, 32'(o));
   endtask : gain_frame

   // Main sequence
   initial
   begin
      rst = 1'b1;
      lane_data_in = 40'h00_0000_0000;
      pix_valid = 1'b0;
      pix_value = 10'h000;
      pix_color = 2'h0;
      frame_end = 1'b0;
      void'($urandom(72314));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (k = 0; k < 14; k++) rreg(tpec_pkg::REG_INDEX[k], tpec_pkg::REG_RESET[k], OK);
      rreg(8'ha8, 16'h0080, OK);
      wreg(8'h97, 16'hffff, ERR);
      rreg(8'h97, 16'h0000, ERR);
      wreg(8'ha8, 16'h0fff, OK);
      rreg(8'ha8, 16'h0080, OK);
      for (k = 0; k < 14; k++)
      begin
         d = 16'($urandom);
         wreg(tpec_pkg::REG_INDEX[k], d, OK);
         rreg(tpec_pkg::REG_INDEX[k], (tpec_pkg::REG_RESET[k] & ~tpec_pkg::REG_MASK[k])
            | (d & tpec_pkg::REG_MASK[k]), OK);
      end
      for (k = 0; k < 4; k++) lane_case(k != 2);
      wreg(8'ha1, 16'h30b8, OK); // Clip 1.5, target 184
      for (k = 0; k < 3; k++) stat_case(2'(k), 16'h0012, 10'h080, 4);
      stat_case(2'h0, 16'h001a, 10'h080, 4);
      stat_case(2'h1, 16'h0012, 10'h040, 1);
      g = 128;
      gain_frame(16'h0013);
      gain_frame(16'h0001);
      gain_frame(16'h0005);
      gain_frame(16'h0011);
      gain_frame(16'h0010);
      rreg(8'ha8, 16'(g), OK);
      give_verdict();
   end
endmodule : tb
